// ==== src/tsc_regs.vh ====
// Constants of the toner supply controller
// What this block does
// - After trailing edge, compute then run supply motor
// - Keep drives on until supply motor stops
// - Supply only at configured copy interval
// - Faulty density sensor: supply every copy
// - Pattern interval is its own setting
// - Copies 1-10 pattern gain, then deviation
// - Gain from latest ratio or reading minus reference
// - Initial setting trims sensor, sets reference
// - Trim failure logs error, forces pixel mode
// - Each good pattern read renews density reference
// - Job end pattern check after interval copies
// - Process control setting also renews reference
// - Bad pattern read logs error, density only
// - Sample density once per copy after edge
// - Sensor mode: out-of-limit reading freezes gain, errors at end
// - Scale page pixel sum to 0..255
// - Ratio maps to gain by threshold table
// - Deviation maps to gain by threshold table
// - On time is gain*pixels*constant/rate plus offset
// - Zero gain drops the offset too
// - Supply rate divisor is a setting
// - Pixel mode uses fixed gain 0.7
// - Sensor or pixel mode, sensor default
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSC_A_CTRL 8'h00
`define TSC_A_SUP_IVL 8'h04
`define TSC_A_PAT_IVL 8'h08
`define TSC_A_RATE 8'h0C
`define TSC_A_AREA_K 8'h10
`define TSC_A_STATUS 8'h14
`define TSC_A_VREF 8'h18
`define TSC_A_LAST 8'h1C
`define TSC_A_CMD 8'h20
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TSC_B_MODE 0
`define TSC_B_INIT 0
`define TSC_B_PCINIT 1
`define TSC_R_MODE 1'b0
`define TSC_R_SUP_IVL 8'h01
`define TSC_R_PAT_IVL 8'h0A
`define TSC_R_RATE 16'h0001
`define TSC_R_AREA_K 8'h07
`define TSC_R_VREF 12'h9C4
// ----------------------------------------
// Timing, limits and gains (mV, tenths)
// ----------------------------------------
`define TSC_CLK_HZ 20000000
`define TSC_OFFSET_MS 32'h00000032
`define TSC_SETTLE_MS 8'h0A
`define TSC_PHASE_COPIES 8'h0A
`define TSC_V_LOW 12'h1F4
`define TSC_V_HIGH 12'hFA0
`define TSC_V_NOM_LO 12'h960
`define TSC_V_NOM_HI 12'hA28
`define TSC_VREF_STEP 12'h014
`define TSC_PIX_GAIN 6'h07
`define TSC_TRIM_INIT 8'h80
`define TSC_TRIM_MAX 8'h40
`define TSC_EC_ADJ 8'h01
`define TSC_EC_PAT 8'h02
`define TSC_EC_OVER 8'h03
`define TSC_EC_UNDER 8'h04
`endif

// ==== src/tsc_top.v ====
// Toner supply controller with its register port
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "tsc_regs.vh"

module tsc_top #(
  parameter MS_CYC = `TSC_CLK_HZ / 1000,
  parameter PIX_LOG2 = 20
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire [7:0] bus_addr_i,
  input wire [31:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  output wire [31:0] bus_rdata_o,
  input wire job_start_i,
  input wire job_end_i,
  input wire engine_run_i,
  input wire page_start_i,
  input wire pix_valid_i,
  input wire [7:0] pix_data_i,
  input wire trail_edge_i,
  input wire [11:0] density_reading_i,
  input wire density_fault_i,
  input wire pattern_done_i,
  input wire pattern_fault_i,
  input wire [9:0] vsp_i,
  input wire [9:0] vsg_i,
  output wire pattern_req_o,
  output wire [7:0] density_trim_o,
  output wire supply_motor_o,
  output wire dev_motor_o,
  output wire drum_motor_o,
  output wire charge_o,
  output wire bias_o
);

  // ----------------------------------------
  // Gain decoders (gain in tenths)
  // ----------------------------------------
  function [5:0] ratio_gain;
    input [9:0] sp;
    input [9:0] sg;
    reg [17:0] p;
    begin
      p = {8'h00, sp} * 18'd200;
      if (p <= sg * 18'd18)
        ratio_gain = 6'd0;
      else if (p <= sg * 18'd25)
        ratio_gain = 6'd10;
      else if (p <= sg * 18'd32)
        ratio_gain = 6'd20;
      else if (p <= sg * 18'd41)
        ratio_gain = 6'd30;
      else if (p <= sg * 18'd100)
        ratio_gain = 6'd40;
      else
        ratio_gain = 6'd10;
    end
  endfunction

  function [5:0] dev_gain;
    input [11:0] vt;
    input [11:0] vr;
    reg signed [12:0] a;
    begin
      a = $signed({1'b0, vt}) - $signed({1'b0, vr});
      if (a < 0)
        dev_gain = 6'd0;
      else if (a < 13'sd60)
        dev_gain = 6'd10;
      else if (a < 13'sd100)
        dev_gain = 6'd20;
      else if (a < 13'sd200)
        dev_gain = 6'd30;
      else
        dev_gain = 6'd40;
    end
  endfunction

  localparam S_IDLE = 2'd0;
  localparam S_SAMP = 2'd1;
  localparam S_CALC = 2'd2;
  localparam S_LOAD = 2'd3;
  localparam I_IDLE = 1'b0;
  localparam I_WAIT = 1'b1;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg mode_q;
  reg [7:0] sup_ivl_q;
  reg [7:0] pat_ivl_q;
  reg [15:0] rate_q;
  reg [7:0] area_k_q;
  reg [11:0] vref_q;
  reg [3:0] err_q;
  reg [7:0] err_code_q;
  reg [31:0] rdata_q;
  reg [1:0] st_q;
  reg [11:0] dens_q;
  reg [7:0] copy_num_q;
  reg [7:0] sup_cnt_q;
  reg [7:0] upd_cnt_q;
  reg [5:0] gain_q;
  reg [5:0] gain_pat_q;
  reg freeze_q;
  reg over_q;
  reg under_q;
  reg pat_bad_q;
  reg [7:0] pix_q;
  reg [15:0] on_ms_q;
  reg [15:0] mcnt_q;
  reg [31:0] tick_q;
  reg [PIX_LOG2+7:0] sum_q;
  reg pat_req_q;
  reg drive_q;
  reg ist_q;
  reg [7:0] trim_q;
  reg [7:0] steps_q;
  reg [7:0] settle_q;

  wire ms_tick = (tick_q == MS_CYC - 1);
  wire wr_ctrl = bus_wr_i && (bus_addr_i == `TSC_A_CTRL);
  wire wr_cmd = bus_wr_i && (bus_addr_i == `TSC_A_CMD);
  wire init_go = wr_cmd && bus_wdata_i[`TSC_B_INIT];
  wire pc_go = wr_cmd && bus_wdata_i[`TSC_B_PCINIT];
  wire clr_err = bus_wr_i && (bus_addr_i == `TSC_A_STATUS);
  wire sens_bad = density_fault_i;

  // Trim finished states and pattern read result
  wire in_tol = (density_reading_i >= `TSC_V_NOM_LO) &&
                (density_reading_i <= `TSC_V_NOM_HI);
  wire settled = (ist_q == I_WAIT) && (settle_q == 8'd0);
  wire trim_ok = settled && in_tol;
  wire trim_fail = settled && !in_tol && (steps_q == `TSC_TRIM_MAX);
  wire pat_ok = pattern_done_i && !pattern_fault_i && (vsg_i != 10'd0);
  wire pat_err = pattern_done_i && !pat_ok;

  // Job end checks
  wire end_over = job_end_i && over_q;
  wire end_under = job_end_i && under_q;

  // Supply interval bookkeeping
  wire [7:0] sup_ivl = (sup_ivl_q == 8'd0) ? 8'd1 : sup_ivl_q;
  wire sup_due = sens_bad || ((sup_cnt_q + 8'd1) >= sup_ivl);

  // On time arithmetic
  wire [15:0] rate = (rate_q == 16'd0) ? 16'd1 : rate_q;
  wire [31:0] prod = {26'd0, gain_q} * {24'd0, pix_q} * {24'd0, area_k_q};
  wire [31:0] den = {16'd0, rate} * 32'd100;
  wire [31:0] quo = prod / den;
  wire [31:0] on_calc = quo + `TSC_OFFSET_MS;

  // Pixel count scaling
  wire [PIX_LOG2+7:0] pix_sh = sum_q >> PIX_LOG2;
  wire [7:0] pix_now = (pix_sh > 255) ? 8'hFF : pix_sh[7:0];

  wire dens_out = (dens_q <= `TSC_V_LOW) || (dens_q >= `TSC_V_HIGH);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= `TSC_R_MODE;
      sup_ivl_q <= `TSC_R_SUP_IVL;
      pat_ivl_q <= `TSC_R_PAT_IVL;
      rate_q <= `TSC_R_RATE;
      area_k_q <= `TSC_R_AREA_K;
    end else begin
      if (trim_fail)
        mode_q <= 1'b1;
      else if (wr_ctrl)
        mode_q <= bus_wdata_i[`TSC_B_MODE];
      if (bus_wr_i && (bus_addr_i == `TSC_A_SUP_IVL))
        sup_ivl_q <= bus_wdata_i[7:0];
      if (bus_wr_i && (bus_addr_i == `TSC_A_PAT_IVL))
        pat_ivl_q <= bus_wdata_i[7:0];
      if (bus_wr_i && (bus_addr_i == `TSC_A_RATE))
        rate_q <= bus_wdata_i[15:0];
      if (bus_wr_i && (bus_addr_i == `TSC_A_AREA_K))
        area_k_q <= bus_wdata_i[7:0];
    end
  end

  // ----------------------------------------
  // Reference, errors and pattern state
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vref_q <= `TSC_R_VREF;
      err_q <= 4'h0;
      err_code_q <= 8'h00;
      pat_bad_q <= 1'b0;
      gain_pat_q <= 6'd0;
      upd_cnt_q <= 8'd0;
      pat_req_q <= 1'b0;
    end else begin
      pat_req_q <= pc_go || (job_end_i && (upd_cnt_q >= pat_ivl_q));
      if (trim_ok)
        vref_q <= density_reading_i;
      else if (pat_ok) begin
        gain_pat_q <= ratio_gain(vsp_i, vsg_i);
        if ({8'h00, vsp_i} * 18'd8 > {8'h00, vsg_i})
          vref_q <= (density_reading_i > `TSC_VREF_STEP) ?
                    density_reading_i - `TSC_VREF_STEP : 12'h000;
        else
          vref_q <= density_reading_i + `TSC_VREF_STEP;
      end
      if (pat_ok)
        upd_cnt_q <= 8'd0;
      else if (st_q == S_SAMP && upd_cnt_q != 8'hFF)
        upd_cnt_q <= upd_cnt_q + 8'd1;
      if (pat_err)
        pat_bad_q <= 1'b1;
      else if (pat_ok)
        pat_bad_q <= 1'b0;
      // Hardware set wins over software clear
      err_q <= (clr_err ? (err_q & ~bus_wdata_i[3:0]) : err_q) |
               {end_under, end_over, pat_err, trim_fail};
      if (trim_fail)
        err_code_q <= `TSC_EC_ADJ;
      else if (pat_err)
        err_code_q <= `TSC_EC_PAT;
      else if (end_over)
        err_code_q <= `TSC_EC_OVER;
      else if (end_under)
        err_code_q <= `TSC_EC_UNDER;
    end
  end

  // ----------------------------------------
  // Sensor initial setting
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ist_q <= I_IDLE;
      trim_q <= `TSC_TRIM_INIT;
      steps_q <= 8'd0;
      settle_q <= 8'd0;
    end else begin
      case (ist_q)
        I_IDLE: begin
          if (init_go) begin
            ist_q <= I_WAIT;
            trim_q <= `TSC_TRIM_INIT;
            steps_q <= 8'd0;
            settle_q <= `TSC_SETTLE_MS;
          end
        end
        I_WAIT: begin
          if (settle_q != 8'd0) begin
            if (ms_tick)
              settle_q <= settle_q - 8'd1;
          end else if (in_tol || steps_q == `TSC_TRIM_MAX) begin
            ist_q <= I_IDLE;
          end else begin
            if (density_reading_i < `TSC_V_NOM_LO)
              trim_q <= trim_q + 8'd1;
            else
              trim_q <= trim_q - 8'd1;
            steps_q <= steps_q + 8'd1;
            settle_q <= `TSC_SETTLE_MS;
          end
        end
        default: ist_q <= I_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pixel accumulation
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      sum_q <= {(PIX_LOG2+8){1'b0}};
    else if (page_start_i)
      sum_q <= {(PIX_LOG2+8){1'b0}};
    else if (pix_valid_i && sum_q[PIX_LOG2+7:PIX_LOG2] != 8'hFF)
      sum_q <= sum_q + {{PIX_LOG2{1'b0}}, pix_data_i};
  end

  // ----------------------------------------
  // Per-copy supply sequence
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= S_IDLE;
      dens_q <= 12'h000;
      copy_num_q <= 8'd0;
      sup_cnt_q <= 8'd0;
      gain_q <= 6'd0;
      freeze_q <= 1'b0;
      over_q <= 1'b0;
      under_q <= 1'b0;
      pix_q <= 8'd0;
      on_ms_q <= 16'd0;
    end else begin
      if (job_start_i) begin
        copy_num_q <= 8'd0;
        freeze_q <= 1'b0;
        over_q <= 1'b0;
        under_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (trail_edge_i)
            st_q <= S_SAMP;
        end
        S_SAMP: begin
          dens_q <= density_reading_i;
          pix_q <= pix_now;
          if (copy_num_q != 8'hFF)
            copy_num_q <= copy_num_q + 8'd1;
          st_q <= S_CALC;
        end
        S_CALC: begin
          if (mode_q)
            gain_q <= `TSC_PIX_GAIN;
          else if (freeze_q || dens_out)
            gain_q <= gain_q;
          else if (copy_num_q <= `TSC_PHASE_COPIES && !pat_bad_q)
            gain_q <= gain_pat_q;
          else
            gain_q <= dev_gain(dens_q, vref_q);
          if (!mode_q && dens_out) begin
            freeze_q <= 1'b1;
            if (dens_q >= `TSC_V_HIGH)
              over_q <= 1'b1;
            else
              under_q <= 1'b1;
          end
          st_q <= S_LOAD;
        end
        S_LOAD: begin
          if (gain_q == 6'd0)
            on_ms_q <= 16'd0;
          else if (on_calc > 32'h0000FFFF)
            on_ms_q <= 16'hFFFF;
          else
            on_ms_q <= on_calc[15:0];
          if (sup_due)
            sup_cnt_q <= 8'd0;
          else
            sup_cnt_q <= sup_cnt_q + 8'd1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Load pulse for the motor counter
  reg load_q;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      load_q <= 1'b0;
    else
      load_q <= (st_q == S_LOAD) && sup_due && (gain_q != 6'd0);
  end

  // ----------------------------------------
  // Millisecond tick and motor counter
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      tick_q <= 32'd0;
    else if (ms_tick || load_q)
      tick_q <= 32'd0;
    else
      tick_q <= tick_q + 32'd1;
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      mcnt_q <= 16'd0;
    else if (load_q)
      mcnt_q <= on_ms_q;
    else if (ms_tick && mcnt_q != 16'd0)
      mcnt_q <= mcnt_q - 16'd1;
  end

  // ----------------------------------------
  // Drive hold
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      drive_q <= 1'b0;
    else
      drive_q <= engine_run_i || (st_q != S_IDLE) || load_q ||
                 (mcnt_q != 16'd0);
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      rdata_q <= 32'h00000000;
    else if (!bus_rd_i)
      rdata_q <= 32'h00000000;
    else begin
      case (bus_addr_i)
        `TSC_A_CTRL: rdata_q <= {31'd0, mode_q};
        `TSC_A_SUP_IVL: rdata_q <= {24'd0, sup_ivl_q};
        `TSC_A_PAT_IVL: rdata_q <= {24'd0, pat_ivl_q};
        `TSC_A_RATE: rdata_q <= {16'd0, rate_q};
        `TSC_A_AREA_K: rdata_q <= {24'd0, area_k_q};
        `TSC_A_STATUS: rdata_q <= {err_code_q, 2'd0, gain_q, 8'd0,
                                   ist_q, (mcnt_q != 16'd0), freeze_q,
                                   pat_bad_q, err_q};
        `TSC_A_VREF: rdata_q <= {20'd0, vref_q};
        `TSC_A_LAST: rdata_q <= {on_ms_q, 8'd0, pix_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign bus_rdata_o = rdata_q;
  assign pattern_req_o = pat_req_q;
  assign density_trim_o = trim_q;
  assign supply_motor_o = (mcnt_q != 16'd0);
  assign dev_motor_o = drive_q;
  assign drum_motor_o = drive_q;
  assign charge_o = drive_q;
  assign bias_o = drive_q;

endmodule // tsc_top

// ==== test/tsc_props.sv ====
// Port checker of the toner supply controller
`timescale 1ns/1ps
module tsc_props #(
  parameter MS_CYC = 20000
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire bus_rd_i,
  input wire [31:0] bus_rdata_o,
  input wire trail_edge_i,
  input wire engine_run_i,
  input wire pattern_req_o,
  input wire [7:0] density_trim_o,
  input wire supply_motor_o,
  input wire dev_motor_o,
  input wire drum_motor_o,
  input wire charge_o,
  input wire bias_o
);
  logic [3:0] te_age_q;
  logic [31:0] run_q;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      te_age_q <= 4'hF;
      run_q <= 32'h0;
    end else begin
      te_age_q <= trail_edge_i ? 4'h0 : te_age_q + {3'h0, te_age_q != 4'hF};
      run_q <= supply_motor_o ? run_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_drive_hold: assert property (supply_motor_o |-> dev_motor_o && charge_o)
    else $error("drives low while supply motor runs");
  a_drive_equal: assert property ({drum_motor_o, charge_o, bias_o} == {3{dev_motor_o}})
    else $error("drive outputs disagree");
  a_drive_release: assert property ($fell(supply_motor_o) && !engine_run_i
    |-> ##[1:3] !dev_motor_o) else $error("drives not released after motor off");
  a_motor_after_edge: assert property ($rose(supply_motor_o) |-> te_age_q inside {[3:8]})
    else $error("motor start not tied to trailing edge");
  a_motor_whole_ms: assert property ($fell(supply_motor_o) |-> run_q % MS_CYC == 0)
    else $error("motor run not whole ticks");
  a_motor_offset: assert property ($rose(supply_motor_o) |-> supply_motor_o[*8])
    else $error("motor run too short");
  a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_pattern_pulse: assert property (pattern_req_o |=> !pattern_req_o)
    else $error("pattern request longer than one cycle");
  a_trim_step: assert property ($changed(density_trim_o) |-> density_trim_o == 8'h80
    || density_trim_o - $past(density_trim_o) inside {8'h01, 8'hFF})
    else $error("trim jumped");
  c_motor: cover property ($rose(supply_motor_o));
  c_pattern: cover property (pattern_req_o);
  c_trim: cover property ($changed(density_trim_o));
endmodule // tsc_props
bind tsc_top tsc_props #(.MS_CYC(MS_CYC)) u_props (.ref_clk_i, .reset_n_i, .bus_rd_i,
  .bus_rdata_o, .trail_edge_i, .engine_run_i, .pattern_req_o, .density_trim_o,
  .supply_motor_o, .dev_motor_o, .drum_motor_o, .charge_o, .bias_o);

// ==== test/tsc_sensor_model.sv ====
// Density and pattern sensor model
`timescale 1ns/1ps
module tsc_sensor_model (
  input wire ref_clk_i,
  input wire pattern_req_i,
  input wire [11:0] set_mv_i,
  input wire [9:0] set_sp_i,
  input wire [9:0] set_sg_i,
  input wire set_fault_i,
  output logic [11:0] density_reading_o,
  output logic pattern_done_o,
  output logic [9:0] vsp_o,
  output logic [9:0] vsg_o,
  output logic pattern_fault_o
);
  logic [3:0] wait_q;
  initial begin
    wait_q = 4'h0;
    {pattern_done_o, vsp_o, vsg_o, pattern_fault_o} = '0;
  end
  assign density_reading_o = set_mv_i;
  // Pattern answer some cycles after the request, scrambled otherwise
  always @(posedge ref_clk_i) begin
    pattern_done_o <= 1'b0;
    wait_q <= pattern_req_i ? 4'h5 : wait_q - {3'h0, wait_q != 4'h0};
    if (wait_q == 4'h1) begin
      pattern_done_o <= 1'b1;
      {vsp_o, vsg_o, pattern_fault_o} <= {set_sp_i, set_sg_i, set_fault_i};
    end else begin
      {vsp_o, vsg_o, pattern_fault_o} <= ~{vsp_o, vsg_o, pattern_fault_o};
    end
  end
endmodule // tsc_sensor_model

// ==== test/tsc_top_tb_top.sv ====
// Testbench of the toner supply controller
`timescale 1ns/1ps
`include "tsc_regs.vh"
module tsc_top_tb_top;
  localparam MS = 20;
  logic ref_clk_i, reset_n_i, bus_wr_i, bus_rd_i, job_start_i, job_end_i, engine_run_i;
  logic page_start_i, pix_valid_i, trail_edge_i, density_fault_i, set_pf;
  logic [7:0] bus_addr_i, pix_data_i;
  logic [31:0] bus_wdata_i, d;
  logic [11:0] set_mv;
  logic [9:0] set_sp, set_sg;
  wire [31:0] bus_rdata_o;
  wire [11:0] density_reading_i;
  wire [9:0] vsp_i, vsg_i;
  wire [7:0] density_trim_o;
  wire pattern_done_i, pattern_fault_i, pattern_req_o, supply_motor_o;
  wire dev_motor_o, drum_motor_o, charge_o, bias_o;
  int err_count, n_compared, hi, n, ms;
  logic [7:0] ra[6] = '{`TSC_A_CTRL, `TSC_A_SUP_IVL, `TSC_A_PAT_IVL, `TSC_A_RATE, `TSC_A_VREF,
    `TSC_A_AREA_K};
  logic [31:0] rv[6] = '{32'h0, 32'h1, 32'hA, 32'h1, 32'h9C4, 32'h7};
  tsc_top #(.MS_CYC(MS), .PIX_LOG2(2)) DUT (.ref_clk_i, .reset_n_i, .bus_addr_i,
    .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .job_start_i, .job_end_i,
    .engine_run_i, .page_start_i, .pix_valid_i, .pix_data_i, .trail_edge_i,
    .density_reading_i, .density_fault_i, .pattern_done_i, .pattern_fault_i, .vsp_i,
    .vsg_i, .pattern_req_o, .density_trim_o, .supply_motor_o, .dev_motor_o,
    .drum_motor_o, .charge_o, .bias_o);
  tsc_sensor_model u_sens (.ref_clk_i, .pattern_req_i(pattern_req_o), .set_mv_i(set_mv),
    .set_sp_i(set_sp), .set_sg_i(set_sg), .set_fault_i(set_pf),
    .density_reading_o(density_reading_i), .pattern_done_o(pattern_done_i),
    .vsp_o(vsp_i), .vsg_o(vsg_i), .pattern_fault_o(pattern_fault_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= v;
    bus_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a);
    @(posedge ref_clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_rd_i <= 1'b0;
    #1 d = bus_rdata_o;
  endtask
  task automatic ev(input int k);
    @(posedge ref_clk_i);
    if (k == 0) job_start_i <= 1'b1;
    else job_end_i <= 1'b1;
    @(posedge ref_clk_i);
    {job_start_i, job_end_i} <= 2'b00;
  endtask
  task automatic copy(input logic [7:0] p);
    @(posedge ref_clk_i);
    page_start_i <= 1'b1;
    @(posedge ref_clk_i);
    page_start_i <= 1'b0;
    pix_data_i <= p;
    pix_valid_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    pix_valid_i <= 1'b0;
    trail_edge_i <= 1'b1;
    @(posedge ref_clk_i);
    trail_edge_i <= 1'b0;
    hi = 0;
    repeat (10) @(posedge ref_clk_i) if (supply_motor_o === 1'b1) hi++;
    while (supply_motor_o === 1'b1) @(posedge ref_clk_i) if (supply_motor_o === 1'b1) hi++;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    err_count++;
    test_done();
  end
  initial begin
    {bus_wr_i, bus_rd_i, job_start_i, job_end_i, engine_run_i, page_start_i} = '0;
    {pix_valid_i, trail_edge_i, density_fault_i, set_pf, reset_n_i} = '0;
    {bus_addr_i, pix_data_i, bus_wdata_i} = '0;
    {set_mv, set_sp, set_sg} = {12'd2500, 10'd250, 10'd1000};
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd32(ra[i]);
      chk(d, rv[i]);
    end
    wr32(`TSC_A_SUP_IVL, 32'h3);
    rd32(`TSC_A_PAT_IVL);
    chk(d, 32'hA);
    rd32(8'hFC);
    chk(d, 32'h0);
    wr32(`TSC_A_SUP_IVL, 32'h1);
    wr32(`TSC_A_CTRL, 32'h1);
    wr32(`TSC_A_RATE, 32'h2);
    ev(0);
    copy(8'hFF);
    ms = 7 * 255 * 7 / 200 + 50;
    chk(hi, ms * MS);
    rd32(`TSC_A_LAST);
    chk(d, {ms[15:0], 16'h00FF});
    wr32(`TSC_A_RATE, 32'h1);
    wr32(`TSC_A_SUP_IVL, 32'h2);
    for (int f = 0; f < 2; f++) begin
      density_fault_i <= f[0];
      ev(0);
      n = 0;
      repeat (2) begin
        copy(8'h00);
        n += (hi > 0);
      end
      chk(n, f + 1);
    end
    density_fault_i <= 1'b0;
    wr32(`TSC_A_SUP_IVL, 32'h1);
    engine_run_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(dev_motor_o, 1'b1);
    engine_run_i <= 1'b0;
    wr32(`TSC_A_CTRL, 32'h0);
    wr32(`TSC_A_CMD, 32'h2);
    repeat (20) @(posedge ref_clk_i);
    rd32(`TSC_A_VREF);
    chk(d, 32'd2480);
    ev(0);
    for (int c = 1; c <= 11; c++) begin
      copy(8'h00);
      rd32(`TSC_A_STATUS);
      chk(d[21:16], c <= 10 ? 6'd40 : 6'd10);
    end
    ev(1);
    n = 0;
    repeat (6) @(posedge ref_clk_i) n += (pattern_req_o === 1'b1);
    chk(n, 1);
    set_sp <= 10'd50;
    wr32(`TSC_A_CMD, 32'h2);
    repeat (20) @(posedge ref_clk_i);
    ev(0);
    copy(8'hFF);
    chk(hi, 0);
    rd32(`TSC_A_LAST);
    chk(d[31:16], 16'h0);
    set_mv <= 12'd4000;
    ev(0);
    copy(8'h00);
    rd32(`TSC_A_STATUS);
    chk(d[5], 1'b1);
    ev(1);
    rd32(`TSC_A_STATUS);
    chk(d[31:24], `TSC_EC_OVER);
    wr32(`TSC_A_STATUS, 32'hF);
    {set_mv, set_pf} <= {12'd2500, 1'b1};
    wr32(`TSC_A_CMD, 32'h2);
    repeat (20) @(posedge ref_clk_i);
    rd32(`TSC_A_STATUS);
    chk({d[31:24], d[4]}, {`TSC_EC_PAT, 1'b1});
    set_mv <= 12'd500;
    ev(0);
    copy(8'h00);
    ev(1);
    rd32(`TSC_A_STATUS);
    chk(d[31:24], `TSC_EC_UNDER);
    {set_mv, set_pf} <= {12'd2550, 1'b0};
    wr32(`TSC_A_CMD, 32'h1);
    repeat (250) @(posedge ref_clk_i);
    rd32(`TSC_A_VREF);
    chk(d, 32'd2550);
    {set_mv, set_pf} <= {12'd1000, 1'b0};
    wr32(`TSC_A_CMD, 32'h1);
    n = 0;
    do begin
      repeat (100) @(posedge ref_clk_i);
      rd32(`TSC_A_STATUS);
      n++;
    end while (d[7] === 1'b1 && n < 200);
    chk(d[31:24], `TSC_EC_ADJ);
    rd32(`TSC_A_CTRL);
    chk(d, 32'h1);
    test_done();
  end
endmodule // tsc_top_tb_top
